/* File: core/fpr_pkg.sv */
// Purpose: shared constants and types for the password read protection block
// Assumes: one device clock, decoded operations arrive as one-cycle requests
// Notes:   widths and field positions of the protection and placement configs
package fpr_pkg;
  localparam int unsigned PWD_W        = 64;
  localparam int unsigned CFG_W        = 16;
  localparam int unsigned ADDR_W       = 32;
  localparam int unsigned SECT_LSB     = 18;        // 256KB sector size
  // protection method config fields
  localparam int unsigned PMC_RDPWD    = 5;
  localparam int unsigned PMC_PWD_HI   = 2;
  localparam int unsigned PMC_PWD_LO   = 1;
  localparam logic [CFG_W-1:0] PMC_RST = 16'hFFFF;
  // placement config fields
  localparam int unsigned BSP_LAYOUT_HI = 9;
  localparam int unsigned BSP_LAYOUT_LO = 8;
  localparam int unsigned BSP_TB_BIT    = 5;
  localparam logic [CFG_W-1:0] BSP_RST  = 16'h0300;
  localparam int unsigned POR_RD_EN_BIT = 0;
  // protection method codes
  localparam logic [1:0] PM_ILLEGAL    = 2'h0;
  localparam logic [1:0] PM_PASSWORD   = 2'h1;
  localparam logic [1:0] PM_PERSIST    = 2'h2;
  localparam logic [1:0] PM_NONE       = 2'h3;
  // timing
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned UNLOCK_SETTLE_NS = 100;
  localparam int unsigned UNLOCK_CYC     = (UNLOCK_SETTLE_NS * CLK_MHZ + 999) / 1000;

  typedef enum logic [3:0] {
    OP_ID_READ   = 4'h0,
    OP_ARRAY_RD  = 4'h1,
    OP_PWD_PROG  = 4'h2,
    OP_PWD_READ  = 4'h3,
    OP_PWD_UNLK  = 4'h4,
    OP_PMC_PROG  = 4'h5,
    OP_PMC_ERASE = 4'h6,
    OP_PSB_PROG  = 4'h7,
    OP_PSB_ERASE = 4'h8,
    OP_LOCK_CLR  = 4'h9,
    OP_BSP_WRITE = 4'hA,
    OP_ARRAY_PGM = 4'hB,
    OP_PSB_READ  = 4'hC,
    OP_DSB_READ  = 4'hD,
    OP_OTHER     = 4'hE
  } fpr_op_e;

  typedef struct packed {
    fpr_op_e            op;
    logic [PWD_W-1:0]   data;
    logic [ADDR_W-1:0]  addr;
  } fpr_req_s;

  typedef struct packed {
    logic               accepted;
    logic               ignored;
    logic               prog_err;
    logic               sect_lock_err;
    logic               rd_valid;
    logic [PWD_W-1:0]   rd_data;
  } fpr_rsp_s;
endpackage : fpr_pkg

/* File: core/fpr_protect.sv */
// Purpose: password store, mode lock, unlock compare, read password address forcing
// Assumes: requests are one-cycle pulses already decoded from the host bus
// Notes:   nonvolatile state modelled by flops reset to delivered values
`timescale 1ns/1ps
`default_nettype none
// How it works
// - password program only clears bits
// - 64-bit password, all ones, any value valid
// - mode lock hides and freezes password
// - serial lane: protected program sets program error
// - octal lane: also sets sector lock error, outside read mode only
// - later password or lock programs abort, reported
// - lock bit never erased back to one
// - lock set after unlock settle time
// - mismatch locks out until reset
// - read mode needs bit5 and bit2 zero
// - force sector bits into boot sector
// - octal placement field picks boot sector
// - serial top/bottom bit picks boot sector
// - power-on read disabled in read mode
// - protection method field decode
// - persistent bits changeable only with lock one
// - reset clears lock in read mode
// - password read undefined while protected
// - only id, unlock, array reads accepted
// - sector bit reads undefined while protected
// - no programming or register writes while protected
// - unlock disables address forcing
// - password method unlock sets lock
// - only unlock sets lock, clear zeroes it
module fpr_protect #(
  parameter int unsigned ADDR_W = fpr_pkg::ADDR_W
) (
  input  wire logic                      clk_i,
  input  wire logic                      arst_n_i,
  input  wire logic                      ce_i,
  input  wire logic                      octal_i,
  input  wire logic                      req_valid_i,
  input  wire fpr_pkg::fpr_req_s         req_i,
  output var  fpr_pkg::fpr_rsp_s         rsp_o,
  output logic [ADDR_W-1:0]              array_addr_o,
  output logic                           lockout_o,
  output logic                           psb_lock_o,
  output logic                           rdpwd_active_o,
  output logic                           por_read_en_o,
  output logic [1:0]                     method_o,
  output logic [fpr_pkg::CFG_W-1:0]      pmc_o,
  output logic [fpr_pkg::CFG_W-1:0]      bsp_o
);
  import fpr_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'b001,
    ST_SETTLE  = 3'b010,
    ST_LOCKOUT = 3'b100
  } fpr_state_e;

  fpr_state_e         state_reg;
  logic [PWD_W-1:0]   pwd_reg;
  logic [CFG_W-1:0]   pmc_reg;
  logic [CFG_W-1:0]   bsp_reg;
  logic               lock_reg;
  logic [7:0]         settle_reg;
  fpr_rsp_s           rsp_next;

  function automatic logic [1:0] method_of(input logic [CFG_W-1:0] c);
    return c[PMC_PWD_HI:PMC_PWD_LO];
  endfunction : method_of

  logic pwd_locked;
  logic rd_mode_sel;
  logic rd_active;
  logic cmd_ok;
  logic is_write_op;
  assign pwd_locked  = ~pmc_reg[PMC_PWD_HI];
  assign rd_mode_sel = ~pmc_reg[PMC_RDPWD];
  assign rd_active   = rd_mode_sel & pwd_locked & ~lock_reg;
  assign cmd_ok      = (req_i.op == OP_ID_READ) || (req_i.op == OP_PWD_UNLK)
                    || (req_i.op == OP_ARRAY_RD);
  assign is_write_op = (req_i.op == OP_PWD_PROG) || (req_i.op == OP_PMC_PROG)
                    || (req_i.op == OP_PSB_PROG) || (req_i.op == OP_PSB_ERASE)
                    || (req_i.op == OP_BSP_WRITE) || (req_i.op == OP_ARRAY_PGM)
                    || (req_i.op == OP_PMC_ERASE) || (req_i.op == OP_LOCK_CLR);

  logic take;
  assign take = ce_i & req_valid_i & (state_reg == ST_IDLE);

  logic pwd_match;
  assign pwd_match = (req_i.data == pwd_reg);

  // control state machine: unlock settle and mismatch lockout
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_reg  <= ST_IDLE;
      settle_reg <= 8'h00;
    end else if (ce_i) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (take && req_i.op == OP_PWD_UNLK) begin
            if (pwd_match && method_of(pmc_reg) == PM_PASSWORD) begin
              state_reg  <= ST_SETTLE;
              settle_reg <= 8'(UNLOCK_CYC - 1);
            end else begin
              state_reg  <= ST_LOCKOUT;
            end
          end
        end
        ST_SETTLE: begin
          if (settle_reg == 8'h00) begin
            state_reg <= ST_IDLE;
          end else begin
            settle_reg <= settle_reg - 8'h01;
          end
        end
        ST_LOCKOUT: state_reg <= ST_LOCKOUT;
        default:    state_reg <= ST_IDLE;
      endcase
    end
  end

  // persistent-bits lock: reset clears it (nonvolatile config flops are reset too)
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lock_reg <= 1'b0;
    end else if (ce_i) begin
      if (state_reg == ST_SETTLE && settle_reg == 8'h00) begin
        lock_reg <= 1'b1;
      end else if (take && req_i.op == OP_LOCK_CLR && !rd_active) begin
        lock_reg <= 1'b0;
      end
    end
  end

  // password store and method config, one-way programming
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwd_reg <= {PWD_W{1'b1}};
      pmc_reg <= PMC_RST;
      bsp_reg <= BSP_RST;
    end else if (take && !rd_active) begin
      if (req_i.op == OP_PWD_PROG && !pwd_locked) begin
        pwd_reg <= pwd_reg & req_i.data;
      end
      if (req_i.op == OP_PMC_PROG && !pwd_locked) begin
        pmc_reg <= pmc_reg & req_i.data[CFG_W-1:0];
      end
      if (req_i.op == OP_BSP_WRITE) begin
        bsp_reg <= req_i.data[CFG_W-1:0];
      end
    end
  end

  // response
  always_comb begin
    rsp_next = '0;
    if (take) begin
      if (rd_active && !cmd_ok) begin
        rsp_next.ignored = 1'b1;
        rsp_next.prog_err = is_write_op;
      end else begin
        rsp_next.accepted = 1'b1;
        unique case (req_i.op)
          OP_PWD_PROG, OP_PMC_PROG: begin
            if (pwd_locked) begin
              rsp_next.accepted      = 1'b0;
              rsp_next.ignored       = 1'b1;
              rsp_next.prog_err      = 1'b1;
              rsp_next.sect_lock_err = octal_i;
            end
          end
          OP_PWD_READ: begin
            if (pwd_locked) begin
              rsp_next.accepted = 1'b0;
              rsp_next.ignored  = 1'b1;
            end else begin
              rsp_next.rd_valid = 1'b1;
              rsp_next.rd_data  = pwd_reg;
            end
          end
          OP_PMC_ERASE: begin
            rsp_next.accepted = 1'b0;
            rsp_next.prog_err = 1'b1;
          end
          OP_PSB_PROG, OP_PSB_ERASE: begin
            if (!lock_reg) begin
              rsp_next.accepted      = 1'b0;
              rsp_next.prog_err      = 1'b1;
              rsp_next.sect_lock_err = octal_i;
            end
          end
          OP_PSB_READ, OP_DSB_READ: begin
            rsp_next.rd_valid = 1'b1;
            rsp_next.rd_data  = '0;
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rsp_o <= '0;
    end else if (ce_i) begin
      rsp_o <= rsp_next;
    end
  end

  // read password address forcing into the boot sector
  logic force_high;
  always_comb begin
    if (octal_i) begin
      force_high = bsp_reg[BSP_LAYOUT_LO];
    end else begin
      force_high = ~bsp_reg[BSP_TB_BIT];
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      array_addr_o <= '0;
    end else if (ce_i && take && req_i.op == OP_ARRAY_RD) begin
      if (rd_active) begin
        array_addr_o <= {{(ADDR_W-SECT_LSB){force_high}},
                         req_i.addr[SECT_LSB-1:0]};
      end else begin
        array_addr_o <= req_i.addr[ADDR_W-1:0];
      end
    end
  end

  assign lockout_o      = (state_reg == ST_LOCKOUT);
  assign psb_lock_o     = lock_reg;
  assign rdpwd_active_o = rd_active;
  // boot read only if not in read password mode
  assign por_read_en_o  = bsp_reg[POR_RD_EN_BIT] & ~(rd_mode_sel & pwd_locked);
  assign method_o       = method_of(pmc_reg);
  assign pmc_o          = pmc_reg;
  assign bsp_o          = bsp_reg;

  // checker helper: edges spent settling, pins the lock rise to the settle time
  // a frozen clock enable stretches settle and count alike, so the check still holds
  logic [7:0] settle_seen_reg;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      settle_seen_reg <= 8'h00;
    end else if (ce_i) begin
      if (state_reg == ST_SETTLE) begin
        settle_seen_reg <= settle_seen_reg + 8'h01;
      end else begin
        settle_seen_reg <= 8'h00;
      end
    end
  end

  // one-way stores: bits only ever fall between resets
  AST_PWD_ONEWAY: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ((pwd_reg & ~$past(pwd_reg)) == '0))
    else $error("password bit rose");
  AST_PMC_ONEWAY: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    ((pmc_reg & ~$past(pmc_reg)) == '0))
    else $error("protection config bit rose");
  AST_LOCK_STAYS: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $fell(pmc_reg[PMC_PWD_HI]) |=> !pmc_reg[PMC_PWD_HI] [*4])
    else $error("mode lock reverted");

  // refused password reads, password and lock programs, and config erase
  AST_LOCKED_PROG_ERR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (take && req_i.op == OP_PWD_PROG && pwd_locked && !rd_active) |=> (rsp_o.prog_err && !rsp_o.accepted))
    else $error("locked program not flagged");
  AST_OCTAL_SLE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (take && req_i.op == OP_PWD_PROG && pwd_locked && octal_i && !rd_active) |=> rsp_o.sect_lock_err)
    else $error("octal sector lock error missing");
  AST_LOCKED_PMC: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (take && req_i.op == OP_PMC_PROG && pwd_locked && !rd_active) |=> (rsp_o.prog_err && rsp_o.ignored))
    else $error("locked config program not aborted");
  AST_LOCKED_READ: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (take && req_i.op == OP_PWD_READ && pwd_locked) |=> !rsp_o.rd_valid)
    else $error("hidden password returned");
  AST_PMC_ERASE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (take && req_i.op == OP_PMC_ERASE && !rd_active) |=> (rsp_o.prog_err && !rsp_o.accepted))
    else $error("config erase accepted");

  // unlock, settle and lockout
  AST_LOCKOUT_HOLD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    lockout_o |=> lockout_o)
    else $error("lockout left without reset");
  AST_LOCKOUT_MUTE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (lockout_o && ce_i) |=> (rsp_o == '0))
    else $error("answer given in lockout");
  AST_MISMATCH: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (take && req_i.op == OP_PWD_UNLK && !pwd_match) |=> lockout_o)
    else $error("mismatch did not lock out");
  AST_UNLOCK_METHOD: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (take && req_i.op == OP_PWD_UNLK && method_of(pmc_reg) != PM_PASSWORD) |=> lockout_o)
    else $error("unlock outside password method");
  AST_SETTLE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && $rose(state_reg == ST_SETTLE)) |-> !lock_reg)
    else $error("lock set early");
  AST_SETTLE_LEN: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(lock_reg) |-> (settle_seen_reg == 8'(UNLOCK_CYC)))
    else $error("settle length wrong");
  AST_LOCK_SOURCE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    $rose(lock_reg) |-> $past(state_reg == ST_SETTLE))
    else $error("lock set outside unlock");
  AST_BUSY_DROP: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && req_valid_i && state_reg != ST_IDLE) |=> (rsp_o == '0))
    else $error("request answered while busy");

  // read password mode
  AST_FORCE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (ce_i && take && req_i.op == OP_ARRAY_RD && rd_active) |=>
    (array_addr_o[ADDR_W-1:SECT_LSB] == {(ADDR_W-SECT_LSB){$past(force_high)}}))
    else $error("address not forced");
  AST_TRUE_ADDR: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (take && req_i.op == OP_ARRAY_RD && !rd_active) |=> (array_addr_o == $past(req_i.addr[ADDR_W-1:0])))
    else $error("address altered outside read mode");
  AST_RD_PWD_PROG: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (take && rd_active && !cmd_ok) |=> (rsp_o.ignored && !rsp_o.accepted))
    else $error("command accepted in read mode");
  AST_RD_WRITE_BLOCK: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (take && rd_active && is_write_op) |=> rsp_o.prog_err)
    else $error("write not flagged in read mode");
  AST_POR_OFF: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_mode_sel && pwd_locked) |-> !por_read_en_o)
    else $error("power-on read left enabled");
  AST_PSB_REFUSE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (take && !rd_active && (req_i.op == OP_PSB_PROG || req_i.op == OP_PSB_ERASE) && !lock_reg)
    |=> (rsp_o.prog_err && !rsp_o.accepted))
    else $error("persistent bits changed while locked");

  // clock enable low freezes every register
  AST_FREEZE: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    !ce_i |=> ($stable(state_reg) && $stable(pwd_reg) && $stable(pmc_reg) && $stable(bsp_reg)
    && $stable(lock_reg) && $stable(rsp_o)))
    else $error("state moved with clock enable low");
endmodule : fpr_protect
`default_nettype wire

/* File: dv/fpr_host_model.sv */
// Purpose: host controller model issuing decoded protection requests
// Assumes: one-cycle request pulse, answer sampled in the cycle after the take edge
// Notes:   released request lines show inverted data and address, only the op stays as last requested
`timescale 1ns/1ps
`default_nettype none
module fpr_host_model (
  input  wire logic              clk_i,
  output var  logic              req_valid_o,
  output var  fpr_pkg::fpr_req_s req_o,
  input  wire fpr_pkg::fpr_rsp_s rsp_i
);
  import fpr_pkg::*;
  initial begin
    req_valid_o = 1'b0;
    req_o       = '0;
  end
  // password read data is never trusted once protection is in use
  task automatic xfer(input fpr_op_e op, input logic [63:0] d, input logic [31:0] a, output fpr_rsp_s r);
    @(posedge clk_i);
    req_valid_o <= 1'b1;
    req_o       <= '{op: op, data: d, addr: a};
    @(posedge clk_i);
    req_valid_o <= 1'b0;
    req_o.data  <= ~d;
    req_o.addr  <= ~a;
    #1;
    r = rsp_i;
  endtask : xfer
endmodule : fpr_host_model
`default_nettype wire

/* File: dv/tb_top.sv */
// Purpose: directed test of password store, mode lock, unlock and read password forcing
// Assumes: every reset returns the stored state to delivered values
// Notes:   settle checked two cycles either side of the nominal count
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fpr_pkg::*;
  localparam logic [63:0] PWD = 64'h00FF000000FF0000;
  logic        clk_i    = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        ce_i     = 1'b1;
  logic        octal_i  = 1'b0;
  logic        req_valid;
  fpr_req_s    req;
  fpr_rsp_s    rsp;
  fpr_rsp_s    r;
  logic [31:0] addr;
  logic        lockout;
  logic        psb_lock;
  logic        rdpwd;
  logic        por_en;
  logic [1:0]  method;
  logic [15:0] pmc;
  logic [15:0] bsp;
  int          error_cnt       = 0;
  int          samples_checked = 0;
  int          cyc             = 0;
  always #5 clk_i = ~clk_i;
  fpr_host_model i_host (.clk_i(clk_i), .req_valid_o(req_valid), .req_o(req), .rsp_i(rsp));
  fpr_protect i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i), .octal_i(octal_i),
    .req_valid_i(req_valid), .req_i(req), .rsp_o(rsp), .array_addr_o(addr), .lockout_o(lockout),
    .psb_lock_o(psb_lock), .rdpwd_active_o(rdpwd), .por_read_en_o(por_en), .method_o(method),
    .pmc_o(pmc), .bsp_o(bsp));
  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict
  task automatic chk_bit(input logic g, input logic e, input string m);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk_bit
  task automatic chk_val(input logic [63:0] g, input logic [63:0] e, input string m);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : chk_val
  task automatic op(input fpr_op_e o, input logic [63:0] d, input logic [31:0] a);
    i_host.xfer(o, d, a, r);
  endtask : op
  task automatic do_reset();
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    arst_n_i <= 1'b1;
    #1;
  endtask : do_reset
  // lock must still be low shortly before the settle count ends
  task automatic unlock(input logic [63:0] p);
    op(OP_PWD_UNLK, p, '0);
    repeat (UNLOCK_CYC - 2) @(posedge clk_i);
    #1;
    chk_bit(psb_lock, 1'b0, "lock early");
    repeat (4) @(posedge clk_i);
    #1;
  endtask : unlock
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      print_verdict();
    end
  end
  initial begin
    do_reset();
    chk_val(64'(pmc), 64'hFFFF, "pmc reset");
    chk_val(64'(bsp), 64'h0300, "bsp reset");
    chk_val(64'(method), 64'(PM_NONE), "method default");
    op(OP_PWD_READ, '0, '0);
    chk_val(r.rd_data, {64{1'b1}}, "pwd delivered");
    op(OP_PWD_PROG, 64'hFFFF0000FFFF0000, '0);
    op(OP_PWD_PROG, 64'h00FFFF0000FFFF00, '0);
    op(OP_PWD_READ, '0, '0);
    chk_val(r.rd_data, PWD, "pwd one way");
    op(OP_PMC_PROG, 64'hFFFB, '0);
    chk_val(64'(method), 64'(PM_PASSWORD), "method pwd");
    op(OP_PWD_READ, '0, '0);
    chk_bit(r.ignored & ~r.rd_valid, 1'b1, "locked read");
    op(OP_PWD_PROG, '0, '0);
    chk_bit(r.prog_err & ~r.sect_lock_err, 1'b1, "serial err");
    @(posedge clk_i) octal_i <= 1'b1;
    op(OP_PWD_PROG, '0, '0);
    chk_bit(r.prog_err & r.sect_lock_err, 1'b1, "octal err");
    @(posedge clk_i) octal_i <= 1'b0;
    op(OP_PMC_PROG, '0, '0);
    chk_bit(r.prog_err, 1'b1, "lock reprogram");
    op(OP_PMC_ERASE, '0, '0);
    chk_bit(r.prog_err, 1'b1, "lock erase");
    chk_val(64'(pmc), 64'hFFFB, "pmc kept");
    op(OP_PSB_PROG, '0, '0);
    chk_bit(r.accepted, 1'b0, "psb locked");
    unlock(PWD);
    chk_bit(psb_lock, 1'b1, "unlock");
    op(OP_PSB_PROG, '0, '0);
    chk_bit(r.accepted, 1'b1, "psb open");
    @(posedge clk_i) ce_i <= 1'b0;
    op(OP_ID_READ, '0, '0);
    chk_bit(r.accepted, 1'b0, "frozen");
    @(posedge clk_i) ce_i <= 1'b1;
    op(OP_LOCK_CLR, '0, '0);
    chk_bit(psb_lock, 1'b0, "lock clear");
    unlock(PWD ^ 64'h1);
    chk_bit(lockout & ~psb_lock, 1'b1, "mismatch");
    op(OP_ID_READ, '0, '0);
    chk_bit(|r, 1'b0, "lockout drop");
    do_reset();
    chk_bit(lockout, 1'b0, "lockout reset");
    op(OP_PWD_PROG, PWD, '0);
    op(OP_BSP_WRITE, 64'h0121, '0);
    chk_bit(por_en, 1'b1, "por read");
    op(OP_PMC_PROG, 64'hFFDB, '0);
    chk_bit(rdpwd & ~por_en, 1'b1, "rdpwd on");
    op(OP_ARRAY_RD, '0, 32'h01012345);
    chk_val(64'(addr), 64'h00012345, "force low");
    @(posedge clk_i) octal_i <= 1'b1;
    op(OP_ARRAY_RD, '0, 32'h00012345);
    chk_val(64'(addr), 64'hFFFD2345, "force high");
    op(OP_BSP_WRITE, '0, '0);
    chk_bit(r.ignored, 1'b1, "write blocked");
    chk_val(64'(bsp), 64'h0121, "bsp kept");
    op(OP_ID_READ, '0, '0);
    chk_bit(r.accepted, 1'b1, "id read");
    op(OP_PSB_READ, '0, '0);
    chk_val(r.rd_data, '0, "psb read");
    unlock(PWD);
    chk_bit(psb_lock & ~rdpwd, 1'b1, "rdpwd off");
    op(OP_ARRAY_RD, '0, 32'h01012345);
    chk_val(64'(addr), 64'h01012345, "true addr");
    do_reset();
    chk_bit(psb_lock, 1'b0, "reset lock");
    print_verdict();
  end
endmodule : tb_top
`default_nettype wire
